// ===== verilog/phy_cfg.svh
`ifndef PHY_CFG_SVH
`define PHY_CFG_SVH

// ----------------------------------------
// Register map of the basic mode control
// ----------------------------------------

`define PBC_ADDR 5'h00
`define PBC_ADDR_W 5
`define PBC_DATA_W 16

// ----------------------------------------
// Field positions
// ----------------------------------------

`define PBC_SW_RESET 15
`define PBC_LOOPBACK 14
`define PBC_SPEED_LO 13
`define PBC_AN_ENABLE 12
`define PBC_POWER_DOWN 11
`define PBC_ISOLATE 10
`define PBC_AN_RESTART 9
`define PBC_DUPLEX 8
`define PBC_SPEED_HI 6

// ----------------------------------------
// Reset value and storage masks
// ----------------------------------------

`define PBC_RESET_VAL 16'h1140
`define PBC_KEEP_MASK 16'h7D40
`define PBC_ZERO_MASK 16'h00BF

`endif

// ===== verilog/phy_pkg.sv
package phy_pkg;

   typedef enum logic [1:0] {
      SPD_10 = 2'h0,
      SPD_100 = 2'h1,
      SPD_1000 = 2'h2,
      SPD_RSVD = 2'h3
   } speed_t;

   typedef enum logic [1:0] {
      RST_IDLE = 2'h1,
      RST_BUSY = 2'h2
   } rst_state_t;

endpackage

// ===== verilog/reset_sync.sv
`timescale 1ns/1ns

module reset_sync (
   input wire logic mclk,
   input wire logic rst_b,
   output logic rst_sync_b
);

   logic [1:0] sync_q;
   logic [1:0] sync_d;

   // ----------------------------------------
   // Release synchroniser
   // ----------------------------------------

   // Assertion is immediate; release waits two edges so no flop sees a runt release.
   always_comb begin
      sync_d = {sync_q[0], 1'b1};
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_q <= 2'h0;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign rst_sync_b = sync_q[1];

endmodule

// ===== verilog/mii_path.sv
`timescale 1ns/1ns

module mii_path (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic loopback,
   input wire logic isolate,
   input wire logic power_down,
   input wire logic [7:0] mac_txd,
   input wire logic mac_tx_en,
   input wire logic [7:0] line_rxd,
   input wire logic line_rx_dv,
   output logic [7:0] mac_rxd,
   output logic mac_rx_dv,
   output logic mac_rx_oe_b,
   output logic [7:0] line_txd,
   output logic line_tx_en
);

   logic [7:0] mac_rxd_q, mac_rxd_d;
   logic mac_rx_dv_q, mac_rx_dv_d;
   logic oe_b_q, oe_b_d;
   logic [7:0] line_txd_q, line_txd_d;
   logic line_tx_en_q, line_tx_en_d;

   // ----------------------------------------
   // Data path steering
   // ----------------------------------------

   // The line side stays quiet in loopback so looped frames never reach the cable.
   always_comb begin
      mac_rxd_d = line_rxd;
      mac_rx_dv_d = line_rx_dv;
      line_txd_d = mac_txd;
      line_tx_en_d = mac_tx_en;
      oe_b_d = isolate;
      if (loopback) begin
         mac_rxd_d = mac_txd;
         mac_rx_dv_d = mac_tx_en;
         line_txd_d = 8'h00;
         line_tx_en_d = 1'b0;
      end
      if (power_down || isolate) begin
         mac_rxd_d = 8'h00;
         mac_rx_dv_d = 1'b0;
         line_txd_d = 8'h00;
         line_tx_en_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mac_rxd_q <= 8'h00;
         mac_rx_dv_q <= 1'b0;
         oe_b_q <= 1'b1;
         line_txd_q <= 8'h00;
         line_tx_en_q <= 1'b0;
      end else begin
         mac_rxd_q <= mac_rxd_d;
         mac_rx_dv_q <= mac_rx_dv_d;
         oe_b_q <= oe_b_d;
         line_txd_q <= line_txd_d;
         line_tx_en_q <= line_tx_en_d;
      end
   end

   assign mac_rxd = mac_rxd_q;
   assign mac_rx_dv = mac_rx_dv_q;
   assign mac_rx_oe_b = oe_b_q;
   assign line_txd = line_txd_q;
   assign line_tx_en = line_tx_en_q;

endmodule

// ===== verilog/phy_basic_mode_control.sv
`timescale 1ns/1ns

`include "phy_cfg.svh"

// Overview of operation
// - Writing the reset bit returns all control and status registers to defaults.
// - The reset bit clears itself and reads one while reset is in progress.
// - Reset ends when auto-negotiation begins or forced mode is entered.
// - Loopback routes transmit data from the MAC back to its receive path.
// - Without auto-negotiation bits 6 and 13 pick 10, 100, 1000 or reserved.
// - With auto-negotiation on, speed and duplex bits are ignored.
// - Speed defaults to high bit one, low bit zero, meaning 1000 Mb/s.
// - Power down stops the port while management accesses still work.
// - Isolate detaches the MAC data interface, management stays usable.
// - Writing restart starts auto-negotiation anew, ignored when it is disabled.
// - Restart reads one until auto-negotiation is initiated, then clears itself.
// - Clearing restart by a write never disturbs a running negotiation.
// - Duplex bit selects full or half duplex when forced, defaults to full.
module phy_basic_mode_control
   import phy_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [`PBC_ADDR_W-1:0] reg_addr,
   input wire logic [`PBC_DATA_W-1:0] reg_wdata,
   output logic [`PBC_DATA_W-1:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic an_begun,
   input wire logic forced_entered,
   output logic an_start_req,
   output logic phy_regs_reset,
   output logic autoneg_enable,
   output logic forced_mode,
   output speed_t forced_speed,
   output logic forced_full_duplex,
   output logic power_down_request,
   output logic isolate_en,
   output logic loopback_en,
   input wire logic [7:0] mac_txd,
   input wire logic mac_tx_en,
   input wire logic [7:0] line_rxd,
   input wire logic line_rx_dv,
   output logic [7:0] mac_rxd,
   output logic mac_rx_dv,
   output logic mac_rx_oe_b,
   output logic [7:0] line_txd,
   output logic line_tx_en
);

   logic rst_n;
   logic wr_hit;
   logic sw_reset_set;
   logic restart_set;
   logic [`PBC_DATA_W-1:0] rd_val;
   logic [`PBC_DATA_W-1:0] ctrl_q, ctrl_d;
   logic restart_q, restart_d;
   rst_state_t state_q, state_d;
   logic regs_reset_q, regs_reset_d;
   logic [`PBC_DATA_W-1:0] rdata_q, rdata_d;
   logic rd_valid_q, rd_valid_d;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------

   reset_sync u_reset_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .rst_sync_b(rst_n)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------

   assign wr_hit = reg_wr_en && (reg_addr == `PBC_ADDR);
   assign sw_reset_set = wr_hit && reg_wdata[`PBC_SW_RESET];
   // The enable seen is the one carried by the same write, so one write can enable and restart.
   assign restart_set = wr_hit && reg_wdata[`PBC_AN_RESTART]
      && reg_wdata[`PBC_AN_ENABLE] && !sw_reset_set;

   // ----------------------------------------
   // Stored control fields
   // ----------------------------------------

   always_comb begin
      ctrl_d = ctrl_q;
      if (sw_reset_set) begin
         ctrl_d = `PBC_RESET_VAL & `PBC_KEEP_MASK;
      end else if (wr_hit) begin
         ctrl_d = reg_wdata & `PBC_KEEP_MASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `PBC_RESET_VAL & `PBC_KEEP_MASK;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ----------------------------------------
   // Restart of auto-negotiation
   // ----------------------------------------

   // A write of zero to the restart bit is not a clear; initiation, a software reset or disabling negotiation clears it.
   always_comb begin
      restart_d = restart_q;
      if (sw_reset_set) begin
         restart_d = 1'b0;
      end else if (restart_set) begin
         restart_d = 1'b1;
      end else if (!ctrl_d[`PBC_AN_ENABLE]) begin
         restart_d = 1'b0;
      end else if (an_begun) begin
         restart_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= restart_d;
      end
   end

   // ----------------------------------------
   // Software reset process
   // ----------------------------------------

   always_comb begin
      state_d = state_q;
      regs_reset_d = sw_reset_set;
      unique case (state_q)
         RST_IDLE: begin
            if (sw_reset_set) begin
               state_d = RST_BUSY;
            end
         end
         RST_BUSY: begin
            if (!sw_reset_set && (an_begun || forced_entered)) begin
               state_d = RST_IDLE;
            end
         end
         default: begin
            state_d = RST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RST_IDLE;
         regs_reset_q <= 1'b0;
      end else begin
         state_q <= state_d;
         regs_reset_q <= regs_reset_d;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------

   always_comb begin
      rd_val = ctrl_q;
      rd_val[`PBC_SW_RESET] = (state_q == RST_BUSY);
      rd_val[`PBC_AN_RESTART] = restart_q;
      rdata_d = rdata_q;
      rd_valid_d = reg_rd_en;
      if (reg_rd_en) begin
         rdata_d = (reg_addr == `PBC_ADDR) ? rd_val : 16'h0000;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rd_valid = rd_valid_q;

   // ----------------------------------------
   // Mode outputs
   // ----------------------------------------

   // Forced settings are always shown, but only count while forced_mode is high.
   assign autoneg_enable = ctrl_q[`PBC_AN_ENABLE];
   assign forced_mode = !ctrl_q[`PBC_AN_ENABLE];
   assign forced_speed = speed_t'({ctrl_q[`PBC_SPEED_HI], ctrl_q[`PBC_SPEED_LO]});
   assign forced_full_duplex = ctrl_q[`PBC_DUPLEX];
   assign power_down_request = ctrl_q[`PBC_POWER_DOWN];
   assign isolate_en = ctrl_q[`PBC_ISOLATE];
   assign loopback_en = ctrl_q[`PBC_LOOPBACK];
   assign phy_regs_reset = regs_reset_q;
   assign an_start_req = restart_q
      || ((state_q == RST_BUSY) && ctrl_q[`PBC_AN_ENABLE]);

   // ----------------------------------------
   // Data path
   // ----------------------------------------

   mii_path u_mii_path (
      .mclk(mclk),
      .rst_n(rst_n),
      .loopback(ctrl_q[`PBC_LOOPBACK]),
      .isolate(ctrl_q[`PBC_ISOLATE]),
      .power_down(ctrl_q[`PBC_POWER_DOWN]),
      .mac_txd(mac_txd),
      .mac_tx_en(mac_tx_en),
      .line_rxd(line_rxd),
      .line_rx_dv(line_rx_dv),
      .mac_rxd(mac_rxd),
      .mac_rx_dv(mac_rx_dv),
      .mac_rx_oe_b(mac_rx_oe_b),
      .line_txd(line_txd),
      .line_tx_en(line_tx_en)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_reset_defaults;
      sw_reset_set |=> (ctrl_q == (`PBC_RESET_VAL & `PBC_KEEP_MASK)) && phy_regs_reset;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("Software reset did not restore defaults.");

   property p_reset_reads_one;
      (state_q == RST_BUSY) && reg_rd_en && (reg_addr == `PBC_ADDR)
         |=> reg_rd_valid && reg_rdata[`PBC_SW_RESET];
   endproperty
   a_reset_reads_one: assert property (p_reset_reads_one)
      else $error("Reset bit read zero while reset in progress.");

   property p_reset_done;
      (state_q == RST_BUSY) && !sw_reset_set && (an_begun || forced_entered)
         |=> (state_q == RST_IDLE);
   endproperty
   a_reset_done: assert property (p_reset_done)
      else $error("Reset did not finish on start of negotiation or forced mode.");

   property p_reset_holds;
      (state_q == RST_BUSY) && !an_begun && !forced_entered |=> (state_q == RST_BUSY);
   endproperty
   a_reset_holds: assert property (p_reset_holds)
      else $error("Reset bit cleared before reset completed.");

   property p_loopback_path;
      loopback_en && !isolate_en && !power_down_request ##1 $stable(loopback_en)
         |-> (mac_rxd == $past(mac_txd)) && (mac_rx_dv == $past(mac_tx_en));
   endproperty
   a_loopback_path: assert property (p_loopback_path)
      else $error("Loopback did not return transmit data.");

   property p_speed_code;
      wr_hit && !sw_reset_set
         |=> forced_speed == speed_t'({$past(reg_wdata[`PBC_SPEED_HI]),
                                       $past(reg_wdata[`PBC_SPEED_LO])});
   endproperty
   a_speed_code: assert property (p_speed_code)
      else $error("Forced speed code does not follow the written bits.");

   property p_forced_follows_enable;
      wr_hit && !sw_reset_set |=> forced_mode == !$past(reg_wdata[`PBC_AN_ENABLE]);
   endproperty
   a_forced_follows_enable: assert property (p_forced_follows_enable)
      else $error("Forced mode does not mirror negotiation enable.");

   property p_speed_default;
      sw_reset_set |=> (forced_speed == SPD_1000) && forced_full_duplex && autoneg_enable;
   endproperty
   a_speed_default: assert property (p_speed_default)
      else $error("Reset speed is not 1000 Mb/s full duplex.");

   property p_power_down_quiet;
      power_down_request ##1 power_down_request |-> !line_tx_en && !mac_rx_dv;
   endproperty
   a_power_down_quiet: assert property (p_power_down_quiet)
      else $error("Port active while powered down.");

   property p_isolate_released;
      isolate_en ##1 isolate_en |-> mac_rx_oe_b && !mac_rx_dv;
   endproperty
   a_isolate_released: assert property (p_isolate_released)
      else $error("MAC receive side still driven while isolated.");

   property p_restart_ignored;
      wr_hit && !reg_wdata[`PBC_AN_ENABLE] |=> !restart_q;
   endproperty
   a_restart_ignored: assert property (p_restart_ignored)
      else $error("Restart pending while negotiation disabled.");

   property p_restart_holds;
      restart_q && !an_begun && !sw_reset_set && autoneg_enable && !wr_hit
         |=> restart_q && an_start_req;
   endproperty
   a_restart_holds: assert property (p_restart_holds)
      else $error("Restart bit cleared before negotiation began.");

   property p_restart_clear_ignored;
      restart_q && wr_hit && !reg_wdata[`PBC_AN_RESTART] && reg_wdata[`PBC_AN_ENABLE]
         && !sw_reset_set && !an_begun |=> restart_q;
   endproperty
   a_restart_clear_ignored: assert property (p_restart_clear_ignored)
      else $error("Management write cleared a pending restart.");

   property p_duplex_field;
      wr_hit && !sw_reset_set |=> forced_full_duplex == $past(reg_wdata[`PBC_DUPLEX]);
   endproperty
   a_duplex_field: assert property (p_duplex_field)
      else $error("Duplex bit not stored.");

   property p_reserved_zero;
      reg_rd_valid |-> (reg_rdata & `PBC_ZERO_MASK) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved bits read nonzero.");

endmodule

// ===== dv/mgmt_ctrl_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// Management controller and negotiation responder
// ----------------------------------------

module mgmt_ctrl_model (
   input wire logic mclk,
   input wire logic an_start_req,
   input wire logic forced_mode,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [4:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic an_begun,
   output logic forced_entered
);
   int an_delay = 8;
   int cnt = 0;
   logic fm_q = 1'b0;

   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      an_begun = 1'b0;
      forced_entered = 1'b0;
   end

   // One strobe cycle per access; released data is inverted so stale values never look valid.
   task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr_en <= wr;
      reg_rd_en <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // A slow engine keeps self-clearing bits visible long enough to be polled.
   always @(posedge mclk) begin
      cnt <= an_start_req ? cnt + 1 : 0;
      an_begun <= an_start_req && (cnt == an_delay);
      fm_q <= forced_mode;
      forced_entered <= forced_mode && !fm_q;
   end
endmodule

// ===== dv/phy_basic_mode_control_tb.sv
`timescale 1ns/1ns

`include "phy_cfg.svh"

module phy_basic_mode_control_tb
   import phy_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr_en, reg_rd_en, an_begun, forced_entered, reg_rd_valid;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic an_start_req, phy_regs_reset, autoneg_enable, forced_mode;
   speed_t forced_speed;
   logic forced_full_duplex, power_down_request, isolate_en, loopback_en;
   logic [7:0] mac_txd = 8'h00, line_rxd = 8'h00, mac_rxd, line_txd;
   logic mac_tx_en = 1'b0, line_rx_dv = 1'b0, mac_rx_dv, mac_rx_oe_b, line_tx_en;
   logic [15:0] exp_q[$];
   int error_cnt = 0, checked = 0, rst_pulses = 0, i;
   int seed = 32'h0519;

   phy_basic_mode_control uut (
      .mclk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rd_valid, .an_begun, .forced_entered, .an_start_req, .phy_regs_reset,
      .autoneg_enable, .forced_mode, .forced_speed, .forced_full_duplex,
      .power_down_request, .isolate_en, .loopback_en, .mac_txd, .mac_tx_en, .line_rxd,
      .line_rx_dv, .mac_rxd, .mac_rx_dv, .mac_rx_oe_b, .line_txd, .line_tx_en
   );

   mgmt_ctrl_model mgmt (
      .mclk, .an_start_req, .forced_mode, .reg_wr_en, .reg_rd_en, .reg_addr,
      .reg_wdata, .an_begun, .forced_entered
   );

   initial begin
      forever #25 mclk = ~mclk;
   end

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      mgmt.access(1'b1, a, v);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      mgmt.access(1'b0, a, 16'h0000);
   endtask

   // Bounded poll: a stuck self-clearing bit shows up as a mismatch, not a hang.
   task automatic wait_an;
      for (int n = 0; n < 100 && an_start_req !== 1'b0; n++) @(posedge mclk);
      chk(an_start_req, 1'b0);
   endtask

   // Mode: 0 normal, 1 loopback, 2 isolate, 3 power down.
   task automatic mii(input int m);
      logic [7:0] t, r;
      t = 8'($random(seed));
      r = 8'($random(seed));
      @(posedge mclk);
      mac_txd <= t;
      line_rxd <= r;
      mac_tx_en <= 1'b1;
      line_rx_dv <= 1'b1;
      @(posedge mclk);
      #1;
      chk(mac_rxd, m == 0 ? r : (m == 1 ? t : 8'h00));
      chk(line_txd, m == 0 ? t : 8'h00);
      chk(mac_rx_dv, m < 2);
      if (m != 3) chk(mac_rx_oe_b, m == 2);
      chk(line_tx_en, m == 0);
      chk({loopback_en, isolate_en, power_down_request}, {m == 1, m == 2, m == 3});
      chk(autoneg_enable, 1'b0);
   endtask

   always @(posedge mclk) begin
      if (phy_regs_reset === 1'b1) rst_pulses <= rst_pulses + 1;
      if (reg_rd_valid === 1'b1) begin
         chk(reg_rdata, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
      end
   end

   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------

   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(5'h00, `PBC_RESET_VAL);
      chk(forced_speed, SPD_1000);
      chk(forced_full_duplex, 1'b1);
      rd(5'h07, 16'h0000);
      wr(5'h03, 16'h0000);
      rd(5'h00, `PBC_RESET_VAL);
      for (i = 0; i < 4; i++) begin
         d = 16'h0000;
         d[13] = i[0];
         d[6] = i[1];
         d[8] = 1'($random(seed));
         wr(5'h00, d);
         rd(5'h00, d);
         chk(forced_speed, {i[1], i[0]});
         chk(forced_full_duplex, d[8]);
         chk(forced_mode, 1'b1);
      end
      repeat (6) begin
         d = 16'($random(seed)) & 16'h7DFF;
         wr(5'h00, d);
         rd(5'h00, d & `PBC_KEEP_MASK);
         chk(forced_mode, !d[12]);
      end
      wr(5'h00, 16'h0200);
      rd(5'h00, 16'h0000);
      chk(an_start_req, 1'b0);
      wr(5'h00, 16'h1340);
      rd(5'h00, 16'h1340);
      chk(an_start_req, 1'b1);
      wr(5'h00, 16'h1140);
      rd(5'h00, 16'h1340);
      wait_an();
      rd(5'h00, 16'h1140);
      wr(5'h00, 16'h4000);
      mii(1);
      wr(5'h00, 16'h0400);
      mii(2);
      wr(5'h00, 16'h0800);
      mii(3);
      rd(5'h00, 16'h0800);
      wr(5'h00, 16'h0000);
      mii(0);
      wr(5'h00, 16'hC000 | 16'($random(seed)));
      rd(5'h00, 16'h9140);
      wait_an();
      rd(5'h00, `PBC_RESET_VAL);
      chk(16'(rst_pulses), 16'h0001);
      repeat (4) @(posedge mclk);
      chk(16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule
